// >>> common/gst_pkg.sv
`default_nettype none

// shared constants for the global status and telemetry register group
package gst_pkg;

	// register offsets on the byte access port of the serial engine
	localparam logic [7:0] ADDR_EVENT_COR      = 8'h03; // clear-on-read event register
	localparam logic [7:0] ADDR_GLOBAL_STATUS  = 8'h05; // global status byte
	localparam logic [7:0] ADDR_DIE_TEMP       = 8'h06; // die temperature code
	localparam logic [7:0] ADDR_SUPPLY_V_LOW   = 8'h07; // supply voltage low byte
	localparam logic [7:0] ADDR_SUPPLY_V_HIGH  = 8'h08; // supply voltage high byte

	// field positions
	localparam int EVT_THERMAL_BIT   = 3; // thermal shutdown event flag
	localparam int STAT_ADDR_LSB     = 2; // target address field, low bit
	localparam int STAT_ADDR_MSB     = 6; // target address field, high bit
	localparam int STAT_STRAP_BIT    = 0; // standalone-mode strap level

	// values after reset, and the answer to unmapped reads
	localparam logic [7:0] GLOBAL_STATUS_RST = 8'h00; // global status byte
	localparam logic [7:0] READ_DATA_RST     = 8'h00; // read data output
	localparam logic [7:0] UNMAPPED_DATA     = 8'h00; // answer to unmapped address

	// cycles from reset release to strap capture
	localparam int STRAP_CAPTURE_CYCLES = 1;

	// strap capture sequence, gray coded along its path
	typedef enum logic [1:0] {
		CAP_WAIT = 2'b00, // reset just released
		CAP_TAKE = 2'b01, // sampling straps this cycle
		CAP_DONE = 2'b11  // straps held for good
	} capture_state_t;

endpackage : gst_pkg

`default_nettype wire

// >>> common/supply_volt_if.sv
`default_nettype none

// carries supply voltage sample and byte reads between top and latch
interface supply_volt_if;
	logic [15:0] sample;    // live 16-bit measurement
	logic        rd_low;    // host reads low byte this cycle
	logic        rd_high;   // host reads high byte this cycle
	logic [7:0]  low_byte;  // low byte as host sees it
	logic [7:0]  high_byte; // high byte, frozen after a low read

	modport latch (
		input  sample,
		input  rd_low,
		input  rd_high,
		output low_byte,
		output high_byte
	);

	modport user (
		output sample,
		output rd_low,
		output rd_high,
		input  low_byte,
		input  high_byte
	);
endinterface : supply_volt_if

`default_nettype wire

// >>> rtl/supply_volt_latch.sv
`default_nettype none

// holds the supply voltage sample and freezes the high byte on a low read
module supply_volt_latch
	import gst_pkg::*;
(
	input  wire logic         sys_clk_in,
	input  wire logic         reset_in,
	supply_volt_if.latch      volt
);

	// whole state of the latch
	typedef struct packed {
		logic [15:0] sample; // registered measurement
		logic [7:0]  hold;   // high byte taken with the last low read
		logic        frozen; // high byte frozen until read
	} latch_state_t;

	latch_state_t s_q;
	latch_state_t s_d;

	// next state
	always_comb begin
		s_d = s_q;
		// live sample keeps tracking the converter
		s_d.sample = volt.sample;
		if (volt.rd_low) begin
			// freeze the upper half of the same sample the host just got
			s_d.hold   = s_q.sample[15:8];
			s_d.frozen = 1'b1;
		end else if (volt.rd_high) begin
			// high read releases the freeze
			s_d.frozen = 1'b0;
		end
	end

	// state register
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// byte views, low at the lower address
	assign volt.low_byte  = s_q.sample[7:0];
	assign volt.high_byte = s_q.frozen ? s_q.hold : s_q.sample[15:8];

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);

	// frozen high byte stays put until the high read
	AST_HIGH_FROZEN: assert property (
		volt.rd_low ##1 (!volt.rd_high && !volt.rd_low)[*2] |-> $stable(volt.high_byte))
		else $error("high byte moved while frozen");

	// high byte after a low read matches that low read's sample
	AST_SAME_SAMPLE: assert property (
		volt.rd_low |=> volt.high_byte == $past(s_q.sample[15:8]))
		else $error("high byte not from low-read sample");

	// without a freeze the high byte tracks the sample one cycle late
	AST_HIGH_TRACKS: assert property (
		(!volt.rd_low && !s_q.frozen) ##1 !s_q.frozen
			|-> volt.high_byte == $past(volt.sample[15:8]))
		else $error("high byte not tracking sample");

	COV_LOW_THEN_HIGH: cover property (volt.rd_low ##[1:8] volt.rd_high);

endmodule : supply_volt_latch

`default_nettype wire

// >>> rtl/global_status_telemetry.sv
`default_nettype none

// Operation
// - set thermal flag bit3 when ports shut hot
// - thermal flag latched, cleared by event register read
// - threshold is over-temp if enabled, else safe
// - read-only global status byte, resets to zero
// - status bits 6:2 show serial target address
// - status bit0 is strap, captured once after reset
// - temperature register holds unsigned code N
// - 16-bit supply voltage, low byte lower address
// - low byte read freezes high byte until read
module global_status_telemetry
	import gst_pkg::*;
#(
	parameter logic [7:0] OVER_TEMP_CODE = 8'hC8, // over-temperature threshold code
	parameter logic [7:0] SAFE_TEMP_CODE = 8'hAA  // safe-temperature threshold code
) (
	input  wire logic        sys_clk_in,           // device clock, 20 MHz
	input  wire logic        reset_in,             // synchronous, active high
	input  wire logic        rd_strobe_in,         // host byte read request
	input  wire logic        wr_strobe_in,         // host byte write request
	input  wire logic [7:0]  reg_addr_in,          // register address
	input  wire logic [7:0]  wr_data_in,           // write data, ignored here
	input  wire logic [4:0]  target_addr_in,       // serial target address pins
	input  wire logic        standalone_strap_in,  // standalone-mode strap pin
	input  wire logic        ports_shut_hot_in,    // all powered ports shut for heat
	input  wire logic        tsd_enable_in,        // shutdown on over-temp enabled
	input  wire logic [7:0]  die_temp_code_in,     // converter temperature code
	input  wire logic [15:0] supply_sample_in,     // converter supply voltage code
	output logic      [7:0]  rd_data_out,          // registered read data
	output logic             rd_valid_out,         // read data valid, one cycle
	output logic             thermal_event_out     // thermal shutdown flag level
);

	// whole state of the register group except the voltage latch
	typedef struct packed {
		capture_state_t cap;       // strap capture sequence
		logic [4:0]     addr;      // captured target address
		logic           strap;     // captured standalone strap
		logic [7:0]     temp;      // latest die temperature code
		logic           thermal;   // sticky thermal shutdown flag
		logic [7:0]     rd_data;   // read answer
		logic           rd_valid;  // answer strobe
	} gst_state_t;

	gst_state_t s_q;
	gst_state_t s_d;

	// link to the voltage latch
	supply_volt_if volt ();

	// thermal condition against the selected threshold
	function automatic logic temp_above(
		input logic [7:0] code,
		input logic       shutdown_en
	);
		logic [7:0] limit;
		limit = shutdown_en ? OVER_TEMP_CODE : SAFE_TEMP_CODE;
		// strictly greater: a code equal to the limit still counts as cool
		return code > limit;
	endfunction

	// assembled global status byte
	function automatic logic [7:0] status_byte(
		input logic [4:0] addr,
		input logic       strap
	);
		logic [7:0] b;
		b = GLOBAL_STATUS_RST; // reserved bits 7 and 1 stay zero
		b[STAT_ADDR_MSB:STAT_ADDR_LSB] = addr;
		b[STAT_STRAP_BIT] = strap;
		return b;
	endfunction

	// event register view, only the thermal bit lives here
	function automatic logic [7:0] event_byte(input logic flag);
		logic [7:0] b;
		b = 8'h00;
		b[EVT_THERMAL_BIT] = flag;
		return b;
	endfunction

	// strobes into the voltage latch
	assign volt.sample  = supply_sample_in;
	assign volt.rd_low  = rd_strobe_in && (reg_addr_in == ADDR_SUPPLY_V_LOW);
	assign volt.rd_high = rd_strobe_in && (reg_addr_in == ADDR_SUPPLY_V_HIGH);

	// voltage byte holder
	supply_volt_latch u_volt (
		.sys_clk_in (sys_clk_in),
		.reset_in   (reset_in),
		.volt       (volt)
	);

	// next state
	always_comb begin
		s_d = s_q;
		s_d.rd_valid = 1'b0;
		// temperature code follows the converter
		s_d.temp = die_temp_code_in;

		// straps caught once, one cycle after reset release
		case (s_q.cap)
			CAP_WAIT: begin
				s_d.cap = CAP_TAKE;
			end
			CAP_TAKE: begin
				s_d.addr  = target_addr_in;
				s_d.strap = standalone_strap_in;
				s_d.cap   = CAP_DONE;
			end
			CAP_DONE: begin
				// held for good
				s_d.cap = CAP_DONE;
			end
			default: begin
				s_d.cap = CAP_WAIT;
			end
		endcase

		// clear on event register read, set wins in the same cycle
		if (rd_strobe_in && (reg_addr_in == ADDR_EVENT_COR)) begin
			s_d.thermal = 1'b0;
		end
		// compare uses the registered code, so a hot code acts one cycle late;
		// the port shutdown report always trails the heat, so nothing is lost
		if (ports_shut_hot_in && temp_above(s_q.temp, tsd_enable_in)) begin
			s_d.thermal = 1'b1;
		end

		// read decode; writes fall through untouched
		// answers use pre-edge state, so a clearing read still shows the flag
		if (rd_strobe_in) begin
			s_d.rd_valid = 1'b1;
			if (reg_addr_in == ADDR_EVENT_COR) begin
				s_d.rd_data = event_byte(s_q.thermal);
			end else if (reg_addr_in == ADDR_GLOBAL_STATUS) begin
				s_d.rd_data = status_byte(s_q.addr, s_q.strap);
			end else if (reg_addr_in == ADDR_DIE_TEMP) begin
				s_d.rd_data = s_q.temp;
			end else if (reg_addr_in == ADDR_SUPPLY_V_LOW) begin
				s_d.rd_data = volt.low_byte;
			end else if (reg_addr_in == ADDR_SUPPLY_V_HIGH) begin
				s_d.rd_data = volt.high_byte;
			end else begin
				s_d.rd_data = UNMAPPED_DATA;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			s_q.cap      <= CAP_WAIT;
			s_q.addr     <= 5'h00;
			s_q.strap    <= 1'b0;
			s_q.temp     <= 8'h00;
			s_q.thermal  <= 1'b0;
			s_q.rd_data  <= READ_DATA_RST;
			s_q.rd_valid <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops
	assign rd_data_out       = s_q.rd_data;
	assign rd_valid_out      = s_q.rd_valid;
	assign thermal_event_out = s_q.thermal;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);

	// helper: status byte as seen now
	logic [7:0] status_now;
	assign status_now = status_byte(s_q.addr, s_q.strap);

	// hot shutdown with temperature above the chosen limit sets the flag
	AST_THERMAL_SET: assert property (
		(ports_shut_hot_in && temp_above(s_q.temp, tsd_enable_in)) |=> thermal_event_out)
		else $error("thermal flag not set");

	// flag only drops after an event register read
	AST_THERMAL_CLEAR: assert property (
		$fell(thermal_event_out) |->
			$past(rd_strobe_in && reg_addr_in == ADDR_EVENT_COR))
		else $error("thermal flag cleared without read");

	// flag rises only on the qualifying condition
	AST_THERMAL_CAUSE: assert property (
		$rose(thermal_event_out) |->
			$past(ports_shut_hot_in && (tsd_enable_in ?
				s_q.temp > OVER_TEMP_CODE : s_q.temp > SAFE_TEMP_CODE)))
		else $error("thermal flag rose without cause");

	// event read returns flag at bit 3 and nothing else
	AST_EVENT_READ: assert property (
		(rd_strobe_in && reg_addr_in == ADDR_EVENT_COR) |=>
			rd_valid_out && rd_data_out == {4'h0, $past(s_q.thermal), 3'h0})
		else $error("event read data wrong");

	// status read shows address and strap, reserved bits zero
	AST_STATUS_READ: assert property (
		(rd_strobe_in && reg_addr_in == ADDR_GLOBAL_STATUS) |=>
			rd_data_out == {1'b0, $past(s_q.addr), 1'b0, $past(s_q.strap)})
		else $error("status read data wrong");

	// straps never change once captured
	AST_STRAP_HELD: assert property (
		(s_q.cap == CAP_DONE) |=> $stable(status_now) && s_q.cap == CAP_DONE)
		else $error("strap changed after capture");

	// temperature read returns the code one cycle old
	AST_TEMP_READ: assert property (
		(rd_strobe_in && reg_addr_in == ADDR_DIE_TEMP) |=>
			rd_data_out == $past(die_temp_code_in, 2))
		else $error("temperature read data wrong");

	// low then high read returns one coherent sample
	AST_VOLT_COHERENT: assert property (
		(rd_strobe_in && reg_addr_in == ADDR_SUPPLY_V_LOW) ##1
			(rd_strobe_in && reg_addr_in == ADDR_SUPPLY_V_HIGH) |=>
			rd_data_out == $past(supply_sample_in[15:8], 3))
		else $error("voltage bytes not coherent");

	// a write alone changes no readable state
	AST_WRITE_IGNORED: assert property (
		(wr_strobe_in && !rd_strobe_in && !ports_shut_hot_in && s_q.cap == CAP_DONE
			&& wr_data_in != 8'h00) |=> $stable(status_now) && $stable(thermal_event_out)
			&& !rd_valid_out)
		else $error("write altered state");

	// reads of unmapped addresses above the supply high byte answer zero
	AST_UNMAPPED: assert property (
		(rd_strobe_in && reg_addr_in > ADDR_SUPPLY_V_HIGH) |=> rd_data_out == UNMAPPED_DATA)
		else $error("unmapped read not zero");

	// unmapped addresses between event and status answer zero too
	AST_UNMAPPED_LOW: assert property (
		(rd_strobe_in && reg_addr_in > ADDR_EVENT_COR && reg_addr_in < ADDR_GLOBAL_STATUS)
			|=> rd_data_out == UNMAPPED_DATA)
		else $error("unmapped low read not zero");

	// no answer without a read request
	AST_VALID_ONLY_READ: assert property (
		!rd_strobe_in |=> !rd_valid_out)
		else $error("answer without read request");

	// every read request is answered on the next edge
	AST_VALID_EACH_READ: assert property (
		rd_strobe_in |=> rd_valid_out)
		else $error("read request not answered");

	// flag holds while no event register read is taken
	AST_THERMAL_HOLD: assert property (
		(thermal_event_out && !(rd_strobe_in && reg_addr_in == ADDR_EVENT_COR))
			|=> thermal_event_out)
		else $error("thermal flag dropped without read");

	// event read clears the flag when nothing sets it again
	AST_THERMAL_READ_CLEARS: assert property (
		(rd_strobe_in && reg_addr_in == ADDR_EVENT_COR
			&& !(ports_shut_hot_in && temp_above(s_q.temp, tsd_enable_in)))
			|=> !thermal_event_out)
		else $error("thermal flag survived event read");

	// status byte stays zero until the straps are taken
	AST_STATUS_BEFORE_CAPTURE: assert property (
		(s_q.cap != CAP_DONE) |-> status_now == GLOBAL_STATUS_RST)
		else $error("status byte not zero before capture");

	// strap capture steps from wait straight to take with no skip
	AST_CAPTURE_ORDER: assert property (
		(s_q.cap == CAP_WAIT) |=> s_q.cap == CAP_TAKE)
		else $error("strap capture skipped a step");

	// capture takes the address and strap pins of that cycle
	AST_CAPTURE_PINS: assert property (
		(s_q.cap == CAP_TAKE) |=> s_q.addr == $past(target_addr_in)
			&& s_q.strap == $past(standalone_strap_in))
		else $error("straps not taken from pins");

	// low byte read returns the sample seen one cycle before the request
	AST_VOLT_LOW_READ: assert property (
		(rd_strobe_in && reg_addr_in == ADDR_SUPPLY_V_LOW) |=>
			rd_data_out == $past(supply_sample_in[7:0], 2))
		else $error("voltage low byte wrong");

	// temperature register follows the converter one cycle late
	AST_TEMP_TRACK: assert property (
		1'b1 |=> s_q.temp == $past(die_temp_code_in))
		else $error("temperature code not tracking");

	COV_THERMAL_SET_CLEAR: cover property ($rose(thermal_event_out) ##[1:20] $fell(thermal_event_out));
	COV_SET_WINS: cover property (ports_shut_hot_in && rd_strobe_in
		&& reg_addr_in == ADDR_EVENT_COR && thermal_event_out);
	COV_STATUS_READ: cover property (rd_strobe_in && reg_addr_in == ADDR_GLOBAL_STATUS
		&& s_q.cap == CAP_DONE);
	COV_VOLT_PAIR: cover property ((rd_strobe_in && reg_addr_in == ADDR_SUPPLY_V_LOW)
		##[1:4] (rd_strobe_in && reg_addr_in == ADDR_SUPPLY_V_HIGH));

endmodule : global_status_telemetry

`default_nettype wire

// >>> dv/host_model.sv
`default_nettype none

// host side of the byte register port, one strobe per access
module host_model (
	input  wire logic       sys_clk_in,    // device clock
	input  wire logic       rd_valid_in,   // answer marker from device
	input  wire logic [7:0] rd_data_in,    // answer byte from device
	output logic            rd_strobe_out, // read request pulse
	output logic            wr_strobe_out, // write request pulse
	output logic      [7:0] reg_addr_out,  // register address
	output logic      [7:0] wr_data_out    // write data
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle values at time zero
	initial begin
		rd_strobe_out = 1'b0;
		wr_strobe_out = 1'b0;
		reg_addr_out  = 8'h00;
		wr_data_out   = 8'h00;
	end

	// one read, answer awaited a bounded number of cycles
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d  = 8'h00;
		@(negedge sys_clk_in);
		rd_strobe_out = 1'b1;
		reg_addr_out  = a;
		@(negedge sys_clk_in);
		rd_strobe_out = 1'b0;
		reg_addr_out  = ~a; // released address shows the inverse
		// answer stands one cycle, starting right after the taking edge
		for (int i = 0; i < 3 && !ok; i++) begin
			if (rd_valid_in === 1'b1) begin
				ok = 1'b1;
				d  = rd_data_in;
			end else begin
				@(negedge sys_clk_in);
			end
		end
	endtask

	// two reads on back to back edges, each answer taken while it stands
	task automatic read_pair(input logic [7:0] a, input logic [7:0] b,
			output logic [7:0] d1, output logic [7:0] d2);
		@(negedge sys_clk_in);
		rd_strobe_out = 1'b1;
		reg_addr_out  = a;
		@(negedge sys_clk_in);
		reg_addr_out  = b; // strobe stays up for the second read
		d1 = rd_data_in;
		@(negedge sys_clk_in);
		rd_strobe_out = 1'b0;
		reg_addr_out  = ~b;
		d2 = rd_data_in;
	endtask

	// one write, device must ignore it
	task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
		@(negedge sys_clk_in);
		wr_strobe_out = 1'b1;
		reg_addr_out  = a;
		wr_data_out   = v;
		@(negedge sys_clk_in);
		wr_strobe_out = 1'b0;
		reg_addr_out  = ~a;
		wr_data_out   = ~v;
	endtask

	// host scaling of the joined supply code, millivolts
	function automatic real to_millivolts(input logic [15:0] code);
		return code * 5.835;
	endfunction

endmodule // host_model

`default_nettype wire

// >>> dv/global_status_telemetry_tb.sv
`default_nettype none

// bench for the global status and telemetry register group
module global_status_telemetry_tb;
	import gst_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] HOT_LIMIT  = 8'hC0; // over-temperature code used here
	localparam logic [7:0] COOL_LIMIT = 8'hA0; // safe-temperature code used here

	logic        sys_clk_in;          // device clock
	logic        reset_in;            // synchronous reset
	logic        rd_strobe_in;        // from host model
	logic        wr_strobe_in;        // from host model
	logic [7:0]  reg_addr_in;         // from host model
	logic [7:0]  wr_data_in;          // from host model
	logic [4:0]  target_addr_in;      // address pins
	logic        standalone_strap_in; // strap pin
	logic        ports_shut_hot_in;   // heat shutdown of ports
	logic        tsd_enable_in;       // threshold select
	logic [7:0]  die_temp_code_in;    // temperature code
	logic [15:0] supply_sample_in;    // supply code
	logic [7:0]  rd_data_out;         // answer byte
	logic        rd_valid_out;        // answer marker
	logic        thermal_event_out;   // thermal flag
	int          fails;               // mismatch count
	int          check_count;         // comparison count
	int          cycle_count;         // timeout counter

	global_status_telemetry #(.OVER_TEMP_CODE(HOT_LIMIT), .SAFE_TEMP_CODE(COOL_LIMIT)) uut (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in), .rd_strobe_in(rd_strobe_in),
		.wr_strobe_in(wr_strobe_in), .reg_addr_in(reg_addr_in), .wr_data_in(wr_data_in),
		.target_addr_in(target_addr_in), .standalone_strap_in(standalone_strap_in),
		.ports_shut_hot_in(ports_shut_hot_in), .tsd_enable_in(tsd_enable_in),
		.die_temp_code_in(die_temp_code_in), .supply_sample_in(supply_sample_in),
		.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
		.thermal_event_out(thermal_event_out));

	host_model host (
		.sys_clk_in(sys_clk_in), .rd_valid_in(rd_valid_out), .rd_data_in(rd_data_out),
		.rd_strobe_out(rd_strobe_in), .wr_strobe_out(wr_strobe_in),
		.reg_addr_out(reg_addr_in), .wr_data_out(wr_data_in));

	// 20 MHz clock
	initial sys_clk_in = 1'b0;
	always #25 sys_clk_in = ~sys_clk_in;

	// hang guard
	always @(posedge sys_clk_in) begin
		cycle_count++;
		if (cycle_count == 2000) begin
			fails++;
			results();
		end
	end

	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one byte comparison
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// read through the host and compare
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		host.read_reg(a, d, ok);
		chk({name, " answered"}, 8'h01, {7'h00, ok});
		chk(name, exp, d);
	endtask

	// straps held once, writes and reserved bits without effect
	task automatic t_status();
		target_addr_in      = 5'h0C;
		standalone_strap_in = 1'b0;
		rd_chk("status after capture", ADDR_GLOBAL_STATUS, 8'h4D);
		host.write_reg(ADDR_GLOBAL_STATUS, 8'hFF);
		repeat (3) begin
			@(negedge sys_clk_in);
			chk("valid after write", 8'h00, {7'h00, rd_valid_out});
		end
		rd_chk("status after write", ADDR_GLOBAL_STATUS, 8'h4D);
		rd_chk("unmapped", 8'h20, UNMAPPED_DATA);
	endtask

	// temperature code passes through, a mid value and the top value
	task automatic t_temp();
		logic [7:0] vals [2];
		vals = '{8'h5A, 8'hFF};
		foreach (vals[i]) begin
			die_temp_code_in = vals[i];
			repeat (3) @(negedge sys_clk_in);
			rd_chk("temperature", ADDR_DIE_TEMP, vals[i]);
		end
	endtask

	// low read freezes the high byte of the same sample
	task automatic t_volt();
		logic [7:0] lo;
		logic [7:0] hi;
		int         mv;
		supply_sample_in = 16'h1234;
		repeat (3) @(negedge sys_clk_in);
		rd_chk("volt low", ADDR_SUPPLY_V_LOW, 8'h34);
		supply_sample_in = 16'hABCD;
		repeat (3) @(negedge sys_clk_in);
		rd_chk("volt high frozen", ADDR_SUPPLY_V_HIGH, 8'h12);
		rd_chk("volt high live", ADDR_SUPPLY_V_HIGH, 8'hAB);
		rd_chk("volt low new", ADDR_SUPPLY_V_LOW, 8'hCD);
		supply_sample_in = 16'h5A3D;
		repeat (3) @(negedge sys_clk_in);
		host.read_pair(ADDR_SUPPLY_V_LOW, ADDR_SUPPLY_V_HIGH, lo, hi);
		chk("pair low", 8'h3D, lo);
		chk("pair high", 8'h5A, hi);
		mv = int'(host.to_millivolts({hi, lo}));
		check_count++;
		if (mv != 134794) begin
			fails++;
			$display("mismatch millivolts expected 134794 seen %0d", mv);
		end
	endtask

	// thermal flag with either threshold selected
	task automatic t_thermal(input logic en);
		logic [7:0] thr;
		logic [7:0] ev;
		thr = en ? HOT_LIMIT : COOL_LIMIT;
		ev = 8'h00;
		ev[EVT_THERMAL_BIT] = 1'b1;
		tsd_enable_in     = en;
		die_temp_code_in  = thr;
		// code must be registered before ports report the heat shutdown
		@(negedge sys_clk_in);
		ports_shut_hot_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		chk("flag at limit", 8'h00, {7'h00, thermal_event_out});
		die_temp_code_in = thr + 8'h01;
		repeat (3) @(negedge sys_clk_in);
		chk("flag above limit", 8'h01, {7'h00, thermal_event_out});
		rd_chk("event read hot", ADDR_EVENT_COR, ev);
		chk("flag kept", 8'h01, {7'h00, thermal_event_out});
		ports_shut_hot_in = 1'b0;
		die_temp_code_in  = 8'h10;
		repeat (4) @(negedge sys_clk_in);
		chk("flag held", 8'h01, {7'h00, thermal_event_out});
		rd_chk("event read", ADDR_EVENT_COR, ev);
		chk("flag cleared", 8'h00, {7'h00, thermal_event_out});
		rd_chk("event reread", ADDR_EVENT_COR, 8'h00);
	endtask

	// main sequence
	initial begin
		fails = 0;
		check_count = 0;
		cycle_count = 0;
		reset_in            = 1'b1;
		target_addr_in      = 5'h13;
		standalone_strap_in = 1'b1;
		ports_shut_hot_in   = 1'b0;
		tsd_enable_in       = 1'b0;
		die_temp_code_in    = 8'h00;
		supply_sample_in    = 16'h0000;
		repeat (12) @(negedge sys_clk_in);
		chk("data in reset", READ_DATA_RST, rd_data_out);
		chk("valid in reset", 8'h00, {7'h00, rd_valid_out});
		chk("flag in reset", 8'h00, {7'h00, thermal_event_out});
		reset_in = 1'b0;
		rd_chk("status before capture", ADDR_GLOBAL_STATUS, GLOBAL_STATUS_RST);
		t_status();
		t_temp();
		t_volt();
		t_thermal(1'b1);
		t_thermal(1'b0);
		results();
	end

endmodule // global_status_telemetry_tb

`default_nettype wire
